/* hw/svwdr_top.sv */
// Supervisor logic: manual debounce, watchdog and reset sequencing.
`timescale 1ns/10ps
`include "svwdr_map.svh"

module svwdr_top
	import svwdr_pkg::*;
#(
	parameter int unsigned DEBOUNCE_CYC = `SVWDR_DEBOUNCE_CYC,
	parameter int unsigned ACTIVE_CYC   = `SVWDR_ACTIVE_CYC,
	parameter int unsigned TO_LOW_CYC   = `SVWDR_TO_LOW_CYC,
	parameter int unsigned TO_OPEN_CYC  = `SVWDR_TO_OPEN_CYC,
	parameter int unsigned TO_HIGH_CYC  = `SVWDR_TO_HIGH_CYC
) (
	input  wire logic       core_clk_i,       // System clock, 50 MHz.
	input  wire logic       rst_i,            // Async reset, high.
	input  wire logic       manual_reset_n_i, // Push-button, low.
	input  wire logic       kick_i,           // Watchdog kick.
	input  wire logic [1:0] timeout_select_i, // 0 low, 1 open, 2 high.
	input  wire logic       tolerance_i,      // 0 = 5 %, 1 = 10 %.
	input  wire logic       below_5pct_i,     // Supply under 5 % trip.
	input  wire logic       below_10pct_i,    // Supply under 10 % trip.
	output logic            reset_o,          // Reset, active high.
	output logic            reset_n_o,        // Drain pin level.
	output logic            reset_n_oe_o      // Drain pin pulls low.
);

	localparam int unsigned W = `SVWDR_CNT_W;

	svwdr_state_type state_q;
	svwdr_state_type state_d;
	svwdr_cause_type cause_w;
	logic [W-1:0]    man_cnt_q;
	logic [W-1:0]    man_cnt_d;
	logic [W-1:0]    wd_cnt_q;
	logic [W-1:0]    wd_cnt_d;
	logic [W-1:0]    hold_cnt_q;
	logic [W-1:0]    hold_cnt_d;
	logic [W-1:0]    wd_limit_w;
	logic            kick_prev_q;
	logic            kick_fall_w;
	logic            man_done_w;
	logic            wd_done_w;
	logic            hold_done_w;
	logic            cause_any_w;
	logic            reset_d;

	// Threshold chosen by the tolerance strap.
	assign cause_w.undervolt = tolerance_i ? below_10pct_i
		: below_5pct_i;

	// Manual debounce: the level must stay low for a full count.
	assign man_done_w = (man_cnt_q == W'(DEBOUNCE_CYC - 1));
	assign cause_w.manual = man_done_w && !manual_reset_n_i;
	assign man_cnt_d = manual_reset_n_i ? '0
		: (man_done_w ? man_cnt_q : man_cnt_q + 1'b1);

	// Falling edge of the kick; one low cycle is enough.
	assign kick_fall_w = kick_prev_q && !kick_i;

	// Timeout limit picked from the three-level select pin.
	assign wd_limit_w =
		(timeout_select_i == `SVWDR_TSEL_LOW)  ? W'(TO_LOW_CYC) :
		(timeout_select_i == `SVWDR_TSEL_OPEN) ? W'(TO_OPEN_CYC) :
		W'(TO_HIGH_CYC);

	// Timeout when the gap reaches the limit without an edge.
	assign wd_done_w = (state_q == SVWDR_ST_RUN) && !kick_fall_w
		&& (wd_cnt_q >= wd_limit_w - 1'b1);
	assign cause_w.watchdog = wd_done_w;

	assign cause_any_w = cause_w.undervolt || cause_w.manual
		|| cause_w.watchdog;

	// Restart the interval on each edge and outside normal run.
	assign wd_cnt_d = (state_q != SVWDR_ST_RUN || kick_fall_w)
		? '0 : wd_cnt_q + 1'b1;

	// Hold counter restarts while any cause persists.
	assign hold_done_w = (hold_cnt_q == W'(ACTIVE_CYC - 1));
	assign hold_cnt_d = (state_q != SVWDR_ST_HOLD || cause_any_w)
		? '0 : (hold_done_w ? hold_cnt_q : hold_cnt_q + 1'b1);

	// Reset sequencer.
	always_comb begin
		state_d = state_q;
		case (state_q)
			SVWDR_ST_HOLD: begin
				if (!cause_any_w && hold_done_w) begin
					state_d = SVWDR_ST_RUN;
				end
			end
			SVWDR_ST_RUN: begin
				if (cause_any_w) begin
					state_d = SVWDR_ST_HOLD;
				end
			end
			default: begin
				state_d = SVWDR_ST_HOLD;
			end
		endcase
	end

	// Reset asserts on the cycle after any cause appears.
	assign reset_d = (state_d == SVWDR_ST_HOLD);

	// Counters and edge history.
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			man_cnt_q   <= '0;
			wd_cnt_q    <= '0;
			hold_cnt_q  <= '0;
			kick_prev_q <= 1'b0;
		end else begin
			man_cnt_q   <= man_cnt_d;
			wd_cnt_q    <= wd_cnt_d;
			hold_cnt_q  <= hold_cnt_d;
			kick_prev_q <= kick_i;
		end
	end

	// State and outputs; reset release starts the power-up hold.
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_q      <= SVWDR_ST_HOLD;
			reset_o      <= `SVWDR_RST_OUT;
			reset_n_o    <= `SVWDR_RST_N_OUT;
			reset_n_oe_o <= `SVWDR_OE_OUT;
		end else begin
			state_q      <= state_d;
			reset_o      <= reset_d;
			reset_n_o    <= !reset_d;
			reset_n_oe_o <= reset_d;
		end
	end

	// Both reset outputs stay complementary.
	comp_outputs_a: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		reset_n_o == !reset_o)
		else $error("reset_n_o is not the complement of reset_o");

	// The drain pin is only enabled while pulling low.
	drain_only_a: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		reset_n_oe_o |-> (!reset_n_o && reset_o))
		else $error("drain pin driven while not pulling low");

	// Undervoltage reaches both outputs on the next edge.
	undervolt_fast_a: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		cause_w.undervolt |=> (reset_o && !reset_n_o && reset_n_oe_o))
		else $error("undervoltage did not assert reset in time");

	// The strap routes the matching comparator.
	tol_select_a: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		(tolerance_i && below_10pct_i) || (!tolerance_i && below_5pct_i)
		|=> reset_o)
		else $error("tolerance strap did not pick its threshold");

	// A manual low held through the debounce count resets.
	manual_hold_a: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		(!manual_reset_n_i && man_cnt_q == W'(DEBOUNCE_CYC - 2))
		##1 !manual_reset_n_i |=> reset_o)
		else $error("held manual reset did not assert reset");

	// A released manual input raises no cause and clears the count.
	manual_glitch_a: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		$rose(manual_reset_n_i) |-> !cause_w.manual
		##1 (man_cnt_q == '0))
		else $error("manual debounce count not cleared on release");

	// Reset only rises when a cause was present.
	rise_cause_a: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		$rose(reset_o) |-> $past(cause_any_w))
		else $error("reset rose without a cause");

	// Watchdog expiry in run state asserts reset.
	wd_timeout_a: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		(state_q == SVWDR_ST_RUN && !kick_fall_w
		&& wd_cnt_q == wd_limit_w - 1'b1) |=> reset_o)
		else $error("watchdog expiry did not assert reset");

	// The interval count never passes the selected limit.
	wd_bound_a: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		(state_q == SVWDR_ST_RUN) |-> (wd_cnt_q < wd_limit_w))
		else $error("watchdog count overran its limit");

	// The select pin maps to the three timeout lengths.
	sel_map_a: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		(timeout_select_i == `SVWDR_TSEL_LOW
			&& wd_limit_w == W'(TO_LOW_CYC))
		|| (timeout_select_i == `SVWDR_TSEL_OPEN
			&& wd_limit_w == W'(TO_OPEN_CYC))
		|| (timeout_select_i[1]
			&& wd_limit_w == W'(TO_HIGH_CYC)))
		else $error("timeout select mapped to the wrong limit");

	// A one-cycle kick low restarts the interval.
	kick_restart_a: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		(kick_i ##1 !kick_i) |=> wd_cnt_q == '0)
		else $error("narrow kick did not restart the interval");

	// Ending a reset pulse starts the interval from zero.
	end_restart_a: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		$fell(reset_o) |-> (wd_cnt_q == '0) ##1 (wd_cnt_q <= 'd1))
		else $error("interval not restarted after reset");

	// Reset only ends after a full quiet active time.
	hold_time_a: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		$fell(reset_o) |-> $past(hold_cnt_q) == W'(ACTIVE_CYC - 1)
		&& !$past(cause_any_w))
		else $error("reset released before the active time");

	// A persisting cause keeps the hold count at zero.
	hold_restart_a: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		(state_q == SVWDR_ST_HOLD && cause_any_w)
		|=> (hold_cnt_q == '0 && reset_o))
		else $error("hold count ran while a cause persisted");

	// The high reset output follows the hold state.
	state_out_a: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		reset_o == (state_q == SVWDR_ST_HOLD))
		else $error("reset output disagrees with the hold state");

	// With no cause the running state keeps reset released.
	run_quiet_a: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		(state_q == SVWDR_ST_RUN && !cause_any_w) |=> !reset_o)
		else $error("reset asserted without a cause");

	// A high manual input clears the debounce count.
	manual_clear_a: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		manual_reset_n_i |=> (man_cnt_q == '0))
		else $error("manual debounce count kept while released");

	// Each low sample before the end value advances the debounce count by one.
	manual_count_a: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		(!manual_reset_n_i && !man_done_w)
		|=> (man_cnt_q == $past(man_cnt_q) + 1'b1))
		else $error("manual debounce count did not advance");

	// Outside normal run the interval count rests at zero.
	wd_idle_a: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		(state_q != SVWDR_ST_RUN) |=> (wd_cnt_q == '0))
		else $error("interval count ran while reset was held");

	// Without an edge the interval count advances each cycle.
	wd_count_a: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		(state_q == SVWDR_ST_RUN && !kick_fall_w)
		|=> (wd_cnt_q == $past(wd_cnt_q) + 1'b1))
		else $error("interval count did not advance");

	// No watchdog cause appears before the selected limit.
	wd_early_a: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		(wd_cnt_q < wd_limit_w - 1'b1) |-> !cause_w.watchdog)
		else $error("watchdog fired before its limit");

	// A full quiet active time releases reset on the next edge.
	hold_release_a: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		(state_q == SVWDR_ST_HOLD && !cause_any_w && hold_done_w)
		|=> !reset_o)
		else $error("reset not released after the active time");

	// The active-time count never passes its end value.
	hold_limit_a: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		hold_cnt_q <= W'(ACTIVE_CYC - 1))
		else $error("active-time count overran its end value");

	// A released reset lets go of the drain pin.
	drain_off_a: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		!reset_o |-> (!reset_n_oe_o && reset_n_o))
		else $error("drain pin still pulled while released");

	// The comparator that the strap does not pick is ignored.
	tol_ignore_a: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		(state_q == SVWDR_ST_RUN && !cause_w.manual
		&& !cause_w.watchdog && (tolerance_i ? !below_10pct_i
		: !below_5pct_i))
		|=> !reset_o)
		else $error("unselected comparator raised reset");

	// Any cause asserts both outputs on the next edge.
	cause_out_a: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		cause_any_w |=> (reset_o && !reset_n_o && reset_n_oe_o))
		else $error("a cause did not assert both outputs");

endmodule : svwdr_top

/* inc/svwdr_map.svh */
// Constants for the supervisor watchdog reset block.
// Summary of operation
// - The manual reset input is filtered so lows under 1 ms never reset and lows over 20 ms always do.
// - Reset is raised when the gap between falling edges of the kick input exceeds the selected timeout.
// - The timeout select pin picks 150 ms when low, 600 ms when open and 1.2 s when high.
// - Kick pulses as narrow as 20 ns count as falling edges, and the processor makes them at least that wide.
// - After the supply recovers, reset stays asserted for the active time of 610 ms, within 250 to 1000 ms.
// - When the supply drops below threshold both reset outputs assert within 50 us.
// - The tolerance input picks the 5 percent threshold when low and the 10 percent threshold when high.
// - The high reset output asserts on undervoltage, manual reset, watchdog timeout or power-up.
// - The low reset output is always the exact complement of the high reset output.
// - The low reset output only ever pulls low and relies on an outside pull-up for its high level.
`ifndef SVWDR_MAP_SVH
`define SVWDR_MAP_SVH

`define SVWDR_CLK_HZ      50000000
`define SVWDR_CYC_PER_MS  (`SVWDR_CLK_HZ / 1000)
`define SVWDR_CYC_PER_US  (`SVWDR_CLK_HZ / 1000000)

`define SVWDR_DEBOUNCE_MS 10
`define SVWDR_DEBOUNCE_CYC (`SVWDR_DEBOUNCE_MS * `SVWDR_CYC_PER_MS)
`define SVWDR_ACTIVE_MS   610
`define SVWDR_ACTIVE_CYC  (`SVWDR_ACTIVE_MS * `SVWDR_CYC_PER_MS)
`define SVWDR_TO_LOW_MS   150
`define SVWDR_TO_LOW_CYC  (`SVWDR_TO_LOW_MS * `SVWDR_CYC_PER_MS)
`define SVWDR_TO_OPEN_MS  600
`define SVWDR_TO_OPEN_CYC (`SVWDR_TO_OPEN_MS * `SVWDR_CYC_PER_MS)
`define SVWDR_TO_HIGH_MS  1200
`define SVWDR_TO_HIGH_CYC (`SVWDR_TO_HIGH_MS * `SVWDR_CYC_PER_MS)
`define SVWDR_FAIL_US     50
`define SVWDR_FAIL_CYC    (`SVWDR_FAIL_US * `SVWDR_CYC_PER_US)

`define SVWDR_CNT_W       26
`define SVWDR_TSEL_LOW    2'h0
`define SVWDR_TSEL_OPEN   2'h1
`define SVWDR_TSEL_HIGH   2'h2
`define SVWDR_RST_OUT     1'h1
`define SVWDR_RST_N_OUT   1'h0
`define SVWDR_OE_OUT      1'h1

`endif

/* inc/svwdr_pkg.sv */
// Types shared by the supervisor watchdog reset block.
package svwdr_pkg;

	// Sequencer states: holding reset or running normally.
	typedef enum logic [0:0] {
		SVWDR_ST_HOLD = 1'b0,
		SVWDR_ST_RUN  = 1'b1
	} svwdr_state_type;

	// Reset causes gathered as one carrier.
	typedef struct packed {
		logic undervolt;
		logic manual;
		logic watchdog;
	} svwdr_cause_type;

endpackage : svwdr_pkg

/* testbench/svwdr_cpu_model.sv */
// Processor model that pulses the watchdog kick input.
`timescale 1ns/10ps
module svwdr_cpu_model (
	input  wire logic       core_clk_i, // System clock.
	input  wire logic       kick_en_i,  // Kicks run while high.
	input  wire logic [7:0] period_i,   // Cycles between kicks.
	output logic            kick_o      // Kick line to the block.
);
	logic [7:0] cnt_q;

	// Start low so the block never sees a false edge at time zero.
	initial begin
		cnt_q = 8'h00;
		kick_o = 1'b0;
	end

	// Each kick stays high for one full 20 ns cycle, then drops.
	always @(posedge core_clk_i) begin
		if (!kick_en_i || cnt_q >= period_i - 8'h01)
			cnt_q <= 8'h00;
		else
			cnt_q <= cnt_q + 8'h01;
		kick_o <= kick_en_i && (cnt_q == 8'h00);
	end
endmodule : svwdr_cpu_model

/* testbench/tb.sv */
// Self-checking bench for the supervisor watchdog reset block.
`timescale 1ns/10ps
module tb;
	localparam int DEB = 20;
	localparam int ACT = 50;
	localparam int LIM [4] = '{30, 60, 90, 90};
	logic       core_clk_i       = 1'b0;
	logic       rst_i            = 1'b1;
	logic       manual_reset_n_i = 1'b1;
	logic       kick_i;
	logic [1:0] timeout_select_i = 2'h0;
	logic       tolerance_i      = 1'b0;
	logic       below_5pct_i     = 1'b0;
	logic       below_10pct_i    = 1'b0;
	logic       reset_o;
	logic       reset_n_o;
	logic       reset_n_oe_o;
	logic       kick_en          = 1'b1;
	logic [7:0] period           = 8'h0a;
	int         bad_count        = 0;
	int         check_count      = 0;
	int         n;
	// The drain pin is pulled up whenever the block lets go of it.
	wire        pin_level        = reset_n_oe_o ? 1'b0 : 1'b1;

	svwdr_top #(.DEBOUNCE_CYC(DEB), .ACTIVE_CYC(ACT), .TO_LOW_CYC(30),
		.TO_OPEN_CYC(60), .TO_HIGH_CYC(90)) svwdr_top_inst (
		.core_clk_i(core_clk_i), .rst_i(rst_i),
		.manual_reset_n_i(manual_reset_n_i), .kick_i(kick_i),
		.timeout_select_i(timeout_select_i), .tolerance_i(tolerance_i),
		.below_5pct_i(below_5pct_i), .below_10pct_i(below_10pct_i),
		.reset_o(reset_o), .reset_n_o(reset_n_o),
		.reset_n_oe_o(reset_n_oe_o));

	svwdr_cpu_model svwdr_cpu_model_inst (.core_clk_i(core_clk_i),
		.kick_en_i(kick_en), .period_i(period), .kick_o(kick_i));

	// Free-running 50 MHz clock.
	initial begin
		forever #10 core_clk_i = ~core_clk_i;
	end

	task automatic check(input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: exp %h got %h", $time, exp, got);
		end
	endtask : check

	// Both outputs and the pin must agree with the expected reset level.
	task automatic check_outs(input logic e);
		check({28'h0, e, ~e, e, ~e},
			{28'h0, reset_o, reset_n_o, reset_n_oe_o, pin_level});
	endtask : check_outs

	// Counts falling clock edges until reset_o reaches lvl, bounded.
	task automatic wait_for(input logic lvl, input int lim, output int c);
		c = 0;
		while (reset_o !== lvl && c < lim) begin
			@(negedge core_clk_i);
			c++;
		end
	endtask : wait_for

	task automatic in_range(input int v, input int lo, input int hi);
		check(32'h1, {31'h0, v >= lo && v <= hi});
	endtask : in_range

	task automatic t_power();
		@(negedge core_clk_i);
		check_outs(1'b1);
		wait_for(1'b0, ACT + 10, n);
		in_range(n, ACT - 1, ACT + 3);
		$display("power-up test done");
	endtask : t_power

	task automatic t_undervolt();
		for (int t = 0; t < 2; t++) begin
			@(posedge core_clk_i);
			tolerance_i <= t[0];
			{below_10pct_i, below_5pct_i} <= t[0] ? 2'h1 : 2'h2;
			repeat (4) @(negedge core_clk_i);
			check_outs(1'b0);
			@(posedge core_clk_i);
			{below_10pct_i, below_5pct_i} <= 2'h3;
			repeat (2) @(negedge core_clk_i);
			check_outs(1'b1);
			@(posedge core_clk_i);
			{below_10pct_i, below_5pct_i} <= 2'h0;
			wait_for(1'b0, ACT + 10, n);
			in_range(n, ACT - 1, ACT + 3);
		end
		$display("undervoltage test done");
	endtask : t_undervolt

	task automatic t_manual();
		@(posedge core_clk_i);
		manual_reset_n_i <= 1'b0;
		repeat (DEB - 3) @(posedge core_clk_i);
		manual_reset_n_i <= 1'b1;
		repeat (5) @(negedge core_clk_i);
		check_outs(1'b0);
		@(posedge core_clk_i);
		manual_reset_n_i <= 1'b0;
		repeat (DEB + 3) @(negedge core_clk_i);
		check_outs(1'b1);
		@(posedge core_clk_i);
		manual_reset_n_i <= 1'b1;
		wait_for(1'b0, ACT + 10, n);
		in_range(n, ACT - 1, ACT + 3);
		$display("manual reset test done");
	endtask : t_manual

	task automatic t_watchdog();
		for (int s = 0; s < 4; s++) begin
			@(posedge core_clk_i);
			timeout_select_i <= s[1:0];
			period <= 8'(LIM[s] - 4);
			repeat (3 * LIM[s]) @(negedge core_clk_i);
			check_outs(1'b0);
			@(negedge kick_i);
			kick_en <= 1'b0;
			wait_for(1'b1, LIM[s] + 10, n);
			in_range(n, LIM[s] - 3, LIM[s] + 3);
			check_outs(1'b1);
			@(posedge core_clk_i);
			kick_en <= 1'b1;
			wait_for(1'b0, ACT + 10, n);
			in_range(n, ACT - 1, ACT + 3);
		end
		$display("watchdog test done");
	endtask : t_watchdog

	// A second reset in mid-run asserts at once and restarts the hold.
	task automatic t_restart();
		@(posedge core_clk_i);
		rst_i <= 1'b1;
		@(negedge core_clk_i);
		check_outs(1'b1);
		repeat (2) @(posedge core_clk_i);
		rst_i <= 1'b0;
		wait_for(1'b0, ACT + 10, n);
		in_range(n, ACT - 1, ACT + 3);
		$display("restart test done");
	endtask : t_restart

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : report_and_stop

	// Main sequence after an eight-cycle reset.
	initial begin
		repeat (8) @(posedge core_clk_i);
		rst_i <= 1'b0;
		t_power();
		t_undervolt();
		t_manual();
		t_watchdog();
		t_restart();
		report_and_stop();
	end

	// Cuts a hang short well past the expected 1700 or so cycles.
	initial begin
		#200000;
		bad_count++;
		report_and_stop();
	end
endmodule : tb
